// >>> logic/cspg_ctrl.sv
// clock-stop readiness and analog power-up control register
// Overview of operation
// - select code picks blocks checked before clearing
// - code 01 waits for every block but the headphone to power down
// - code 01 needs headset detect idle
// - bit 2 powers supply monitor up
// - bit 1 powers ring detector up
module cspg_ctrl
  import cspg_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register access from the control link
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // clock-stop handshake with the link logic
  input wire logic clock_stop_request,
  output logic clock_stop_pending,
  output logic clock_stop_exit,
  // link clock pin
  input wire logic link_clock_input,
  // power-down status of the blocks being watched
  input wire logic dac_power_down,
  input wire logic capture_converter_power_down,
  input wire logic headphone_power_down,
  input wire logic digital_audio_tx_power_down,
  input wire logic headset_power_down,
  input wire logic mic_bias_power_down,
  input wire logic [1:0] headset_detect_control,
  // analog power enables
  output logic supply_monitor_power_up,
  output logic ring_detect_power_up
);
  // all state of the module except the reset release pipe
  typedef struct packed {
    cspg_state_t state;  // handshake state
    logic [1:0] ready_sel;  // clock_stop_ready_select
    logic vmon;  // supply monitor enable
    logic ring;  // ring detector enable
    logic pending;  // clock-stop pending flag
    logic exit_q;  // clock-stop exit pulse
    logic [7:0] rdata;  // read data
  } cspg_main_t;

  cspg_main_t st;
  cspg_main_t next_st;
  logic [1:0] rst_pipe;  // reset release pipe
  logic rst_sync_n;  // released reset
  logic link_edge;  // link clock rising edge
  logic ready;  // selected blocks are down
  logic wr_hit;  // write to this register
  logic rd_hit;  // read of this register

  // readiness test for a select code
  function automatic logic cspg_ready(input logic [1:0] sel, input logic dac,
      input logic adc, input logic hp, input logic tx, input logic hs,
      input logic mb, input logic [1:0] hsdet);
    logic hsdet_idle;
    hsdet_idle = (hsdet == CSPG_HSDET_IDLE_A) || (hsdet == CSPG_HSDET_IDLE_B);
    unique case (sel)
      CSPG_SEL_NONE: cspg_ready = 1'b1;  // nothing to wait
      CSPG_SEL_PARTIAL: cspg_ready = adc & hp & tx;  // three blocks only
      // every block but the headphone down plus idle headset detect; reserved code acts the same
      // so a bad write can never release clock stop early
      default: cspg_ready = dac & adc & tx & hs & mb & hsdet_idle;
    endcase
  endfunction : cspg_ready

  // register image; reserved positions are constant zero
  function automatic logic [7:0] cspg_image(input logic [1:0] sel, input logic vm,
      input logic rg);
    logic [7:0] img;
    img = 8'h00;
    img[CSPG_SEL_MSB:CSPG_SEL_LSB] = sel;
    img[CSPG_VMON_BIT] = vm;
    img[CSPG_RING_BIT] = rg;
    cspg_image = img & ~CSPG_RSVD_MASK;
  endfunction : cspg_image

  // reset released through two flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe[1];

  // link clock sensing
  cspg_link_sense u_sense (
    .clk_sys(clk_sys),
    .rst_sync_n(rst_sync_n),
    .link_clock_input(link_clock_input),
    .link_edge(link_edge)
  );

  assign wr_hit = reg_wr_en && (reg_addr == CSPG_REG_OFFSET);
  assign rd_hit = reg_rd_en && (reg_addr == CSPG_REG_OFFSET);
  assign ready = cspg_ready(st.ready_sel, dac_power_down, capture_converter_power_down,
      headphone_power_down, digital_audio_tx_power_down, headset_power_down,
      mic_bias_power_down, headset_detect_control);

  // next-state logic
  always_comb begin
    next_st = st;
    next_st.exit_q = 1'b0;
    // register writes; only the select and enables are stored
    if (wr_hit) begin
      // the select only changes what is checked, it drives no power-down
      next_st.ready_sel = reg_wdata[CSPG_SEL_MSB:CSPG_SEL_LSB];
      next_st.vmon = reg_wdata[CSPG_VMON_BIT];
      next_st.ring = reg_wdata[CSPG_RING_BIT];
    end
    // reads return the image, other addresses read zero
    if (rd_hit) begin
      next_st.rdata = cspg_image(st.ready_sel, st.vmon, st.ring);
    end else if (reg_rd_en) begin
      next_st.rdata = 8'h00;
    end
    // clock-stop handshake
    unique case (st.state)
      CSPG_IDLE: begin
        if (clock_stop_request) begin
          next_st.state = CSPG_PENDING;
          next_st.pending = 1'b1;
        end
      end
      CSPG_PENDING: begin
        if (!clock_stop_request) begin
          // request withdrawn before the blocks settled
          next_st.state = CSPG_IDLE;
          next_st.pending = 1'b0;
        end else if (ready) begin
          // selected blocks are down, release the bus manager
          next_st.state = CSPG_STOPPED;
          next_st.pending = 1'b0;
        end
      end
      CSPG_STOPPED: begin
        // link clock restarting marks the exit from clock stop
        if (link_edge) begin
          next_st.exit_q = 1'b1;
          next_st.state = CSPG_IDLE;
        end else if (!clock_stop_request) begin
          next_st.state = CSPG_IDLE;
        end
      end
      default: begin
        next_st.state = CSPG_IDLE;
        next_st.pending = 1'b0;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st.state <= CSPG_IDLE;
      st.ready_sel <= CSPG_SEL_RESET;
      st.vmon <= CSPG_VMON_RESET;
      st.ring <= CSPG_RING_RESET;
      st.pending <= 1'b0;
      st.exit_q <= 1'b0;
      st.rdata <= 8'h00;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign reg_rdata = st.rdata;
  assign clock_stop_pending = st.pending;
  assign clock_stop_exit = st.exit_q;
  assign supply_monitor_power_up = st.vmon;
  assign ring_detect_power_up = st.ring;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_sync_n);

  a_sel_write_store: assert property (wr_hit |=>
      st.ready_sel == $past(reg_wdata[CSPG_SEL_MSB:CSPG_SEL_LSB]))
    else $error("select field did not take the written value");

  a_no_block_wait: assert property ((st.state == CSPG_PENDING && clock_stop_request
      && st.ready_sel == CSPG_SEL_NONE) |=> !clock_stop_pending)
    else $error("code 00 did not clear pending at once");

  a_partial_hold: assert property ((st.state == CSPG_PENDING && clock_stop_request
      && st.ready_sel == CSPG_SEL_PARTIAL && !headphone_power_down) |=> clock_stop_pending)
    else $error("pending cleared with headphone still up");

  a_full_dac_hold: assert property ((st.state == CSPG_PENDING && clock_stop_request
      && st.ready_sel == CSPG_SEL_FULL && !dac_power_down) |=> clock_stop_pending)
    else $error("pending cleared with playback converter still up");

  a_hsdet_busy_hold: assert property ((st.state == CSPG_PENDING && clock_stop_request
      && st.ready_sel == CSPG_SEL_FULL && headset_detect_control[0]) |=> clock_stop_pending)
    else $error("pending cleared while headset detect busy");

  a_vmon_enable: assert property (wr_hit |=>
      supply_monitor_power_up == $past(reg_wdata[CSPG_VMON_BIT]))
    else $error("supply monitor enable did not follow the write");

  a_ring_enable: assert property (wr_hit |=>
      ring_detect_power_up == $past(reg_wdata[CSPG_RING_BIT]))
    else $error("ring detector enable did not follow the write");

  a_rsvd_read_zero: assert property (rd_hit |=>
      ((reg_rdata & CSPG_RSVD_MASK) == 8'h00) && (reg_rdata[CSPG_SEL_MSB:CSPG_SEL_LSB]
      == $past(st.ready_sel)))
    else $error("read image wrong or reserved bits set");
endmodule : cspg_ctrl

// >>> logic/cspg_link_sense.sv
// link clock synchroniser and edge finder
module cspg_link_sense
  import cspg_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_sync_n,
  // link clock pin
  input wire logic link_clock_input,
  // one-cycle pulse per link clock rising edge
  output logic link_edge
);
  // all state in one word
  typedef struct packed {
    logic meta;  // first stage, read only by the second
    logic sync;  // second stage
    logic last;  // previous synchronised level
    logic edge_q;  // registered edge pulse
  } cspg_sense_t;

  cspg_sense_t st;
  cspg_sense_t next_st;

  // next-state: two flops before any logic looks at the pin
  always_comb begin
    next_st = st;
    next_st.meta = link_clock_input;
    next_st.sync = st.meta;
    next_st.last = st.sync;
    next_st.edge_q = st.sync & ~st.last;
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign link_edge = st.edge_q;
endmodule : cspg_link_sense

// >>> logic/cspg_pkg.sv
// constants and types for the clock-stop power-gate control register
package cspg_pkg;
  // register location on the control link
  localparam logic [15:0] CSPG_REG_OFFSET = 16'h1103;
  // field positions
  localparam int CSPG_SEL_LSB = 5;
  localparam int CSPG_SEL_MSB = 6;
  localparam int CSPG_VMON_BIT = 2;
  localparam int CSPG_RING_BIT = 1;
  // reset values
  localparam logic [1:0] CSPG_SEL_RESET = 2'h1;
  localparam logic CSPG_VMON_RESET = 1'b0;
  localparam logic CSPG_RING_RESET = 1'b0;
  // readiness select codes
  localparam logic [1:0] CSPG_SEL_NONE = 2'h0;
  localparam logic [1:0] CSPG_SEL_FULL = 2'h1;
  localparam logic [1:0] CSPG_SEL_PARTIAL = 2'h2;
  localparam logic [1:0] CSPG_SEL_RSVD = 2'h3;
  // idle codes of the headset detect control
  localparam logic [1:0] CSPG_HSDET_IDLE_A = 2'h0;
  localparam logic [1:0] CSPG_HSDET_IDLE_B = 2'h2;
  // bits that always read zero
  localparam logic [7:0] CSPG_RSVD_MASK = 8'h99;

  // clock-stop handshake states
  typedef enum logic [1:0] {
    CSPG_IDLE,
    CSPG_PENDING,
    CSPG_STOPPED
  } cspg_state_t;
endpackage : cspg_pkg

// >>> tb/cspg_link_model.sv
// bus manager model: clock-stop request level and link clock bursts
module cspg_link_model (
  // system clock, only used to time the request
  input wire logic clk_sys,
  // clock-stop request and link clock pin
  output logic clock_stop_request,
  output logic link_clock_input
);
  timeunit 1ns;
  timeprecision 1ns;
  // link clock idles low, request idles off
  initial begin
    clock_stop_request = 1'b0;
    link_clock_input = 1'b0;
  end
  // request moves off the sampling edge so the block sees a clean level
  task automatic set_request(input logic v);
    @(negedge clk_sys);
    clock_stop_request = v;
  endtask : set_request
  // link clock runs only inside a burst; odd offset keeps it out of phase
  // exit is marked on the link clock alone, the source the clock must sit on
  // before the pll is stopped, so no command is lost on the way out
  task automatic burst(input int n);
    #3;
    repeat (n) begin
      #40 link_clock_input = 1'b1;
      #40 link_clock_input = 1'b0;
    end
  endtask : burst
endmodule : cspg_link_model

// >>> tb/tb_clock_stop_power_gate_ctrl.sv
// testbench for the clock-stop power-gate control register
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module tb_clock_stop_power_gate_ctrl
  import cspg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, rst_n = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
  logic [15:0] reg_addr = 16'h0;
  logic [7:0] reg_wdata = 8'h0, reg_rdata, d;
  logic clock_stop_request, clock_stop_pending, clock_stop_exit, link_clock_input;
  logic [5:0] pd = 6'h0; // dac, adc, hp, tx, headset, mic bias
  logic [1:0] hsdet = 2'h1;
  logic supply_monitor_power_up, ring_detect_power_up;
  int n_errors = 0, checks_done = 0, n_exit = 0, cycles = 0;
  // sel, power-down mask, headset detect code, expected readiness
  // code 10 is tried with the transmitter and with the headphone still up
  localparam logic [10:0] CASES [9] = '{{2'h0, 6'h00, 2'h1, 1'h1},
    {2'h2, 6'h1c, 2'h1, 1'h1}, {2'h2, 6'h18, 2'h1, 1'h0}, {2'h2, 6'h14, 2'h1, 1'h0},
    {2'h1, 6'h3f, 2'h1, 1'h0}, {2'h1, 6'h37, 2'h2, 1'h1}, {2'h1, 6'h1f, 2'h0, 1'h0},
    {2'h3, 6'h3f, 2'h1, 1'h0}, {2'h3, 6'h3f, 2'h0, 1'h1}};
  cspg_link_model lm (.clk_sys(clk_sys), .clock_stop_request(clock_stop_request),
    .link_clock_input(link_clock_input));
  cspg_ctrl dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .clock_stop_request(clock_stop_request),
    .clock_stop_pending(clock_stop_pending), .clock_stop_exit(clock_stop_exit),
    .link_clock_input(link_clock_input), .dac_power_down(pd[5]),
    .capture_converter_power_down(pd[4]), .headphone_power_down(pd[3]),
    .digital_audio_tx_power_down(pd[2]), .headset_power_down(pd[1]),
    .mic_bias_power_down(pd[0]), .headset_detect_control(hsdet),
    .supply_monitor_power_up(supply_monitor_power_up),
    .ring_detect_power_up(ring_detect_power_up));
  // 100 MHz system clock
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // count exit pulses and cut a hang short; the falling edge sees settled outputs
  always @(negedge clk_sys) begin
    if (clock_stop_exit === 1'b1) n_exit++;
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic reg_write(input logic [15:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    {reg_wr_en, reg_addr, reg_wdata} = {1'b1, a, v};
    @(negedge clk_sys);
    reg_wr_en = 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [15:0] a, output logic [7:0] v);
    @(negedge clk_sys);
    {reg_rd_en, reg_addr} = {1'b1, a};
    @(negedge clk_sys);
    reg_rd_en = 1'b0;
    @(negedge clk_sys);
    v = reg_rdata;
  endtask : reg_read
  // reset values and the power enables that follow them
  task automatic t_reset();
    reg_read(CSPG_REG_OFFSET, d);
    `CHK(d, 8'h20)
    `CHK(supply_monitor_power_up, 1'b0)
    `CHK(ring_detect_power_up, 1'b0)
  endtask : t_reset
  // reserved bits, enables and an unmapped address
  task automatic t_bits();
    reg_write(CSPG_REG_OFFSET, 8'hff);
    reg_read(CSPG_REG_OFFSET, d);
    `CHK(d, 8'h66)
    `CHK({supply_monitor_power_up, ring_detect_power_up}, 2'h3)
    // unmapped read while the image is non-zero, so a missed decode shows
    reg_read(16'h1104, d);
    `CHK(d, 8'h00)
    reg_write(CSPG_REG_OFFSET, 8'h99);
    reg_write(16'h1104, 8'hff);
    reg_read(CSPG_REG_OFFSET, d);
    `CHK(d, 8'h00)
    `CHK({supply_monitor_power_up, ring_detect_power_up}, 2'h0)
  endtask : t_bits
  // every select code against a ready block set, codes 01 to 11 also against not-ready ones
  task automatic t_ready();
    for (int i = 0; i < 9; i++) begin
      reg_write(CSPG_REG_OFFSET, {1'b0, CASES[i][10:9], 5'h0});
      // blocks are powered down by separate commands, never by the select
      @(negedge clk_sys);
      {pd, hsdet} = CASES[i][8:1];
      lm.set_request(1'b1);
      repeat (4) @(negedge clk_sys);
      `CHK(clock_stop_pending, ~CASES[i][0])
      if (CASES[i][0]) begin
        n_exit = 0;
        lm.burst(1);
        repeat (6) @(negedge clk_sys);
        `CHK(n_exit, 1)
      end
      lm.set_request(1'b0);
      repeat (3) @(negedge clk_sys);
      `CHK(clock_stop_pending, 1'b0)
    end
  endtask : t_ready
  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  // reset for 20 cycles, then the scenarios
  initial begin
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    t_reset();
    t_bits();
    t_ready();
    print_verdict();
  end
endmodule : tb_clock_stop_power_gate_ctrl
